// file: core/host_bus_cfg.svh
/*
 * Constants for the host bus decode and external RAM gating block: address window,
 * timing figures and divider counts.
 * Assumes the including file is compiled after host_bus_pkg.
 */
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

// =====================================================================
// host address map
`define HB_ADDR_W 17
`define HB_ONCHIP_W 6
`define HB_ONCHIP_LAST 17'h0003f
`define HB_DATA_W 8

// =====================================================================
// timing
`define HB_CLK_HZ 10000000
`define HB_REC_TIME_MS 150
`define HB_REC_CYCLES (`HB_REC_TIME_MS * `HB_CLK_HZ / 1000)
`define HB_REC_CNT_W 21
`define HB_SQW_HALF_EDGES 5'h10
`define HB_SQW_CNT_W 5
`define HB_IRQ_PULSE_CYCLES 16
`define HB_IRQ_CNT_W 8

`endif

// file: core/host_bus_pkg.sv
/*
 * Types shared by the host bus decode block and its testbench.
 * Assumes nothing of its surroundings.
 */
package host_bus_pkg;

	// =====================================================================
	// power supervision states
	typedef enum logic [1:0] {
		PWR_FAIL,
		PWR_RECOVER,
		PWR_GOOD
	} pwr_state_t;

	// =====================================================================
	// which alarm drives the primary interrupt pin
	typedef enum logic {
		ROUTE_TOD_PRIMARY,
		ROUTE_WDOG_PRIMARY
	} irq_route_t;

endpackage

// file: core/reg_store.sv
/*
 * Small synchronous memory for the 64 on-chip timekeeping and user bytes.
 * Read data come out of a register one clock after the address.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none

module reg_store #(
	parameter int AW = 6,
	parameter int DW = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [DW-1:0] i_wr_data,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [DW-1:0] o_rd_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array: contents must survive a reset like backed-up storage
	always_ff @(posedge i_ref_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= mem[i_rd_addr];
		end
	end

endmodule

`default_nettype wire

// file: core/host_bus_decode_sram_gating.sv
/*
 * Host bus interface of a timekeeping controller: address decode into the on-chip
 * window or external static RAM, RAM enable gating under power supervision,
 * data bus drivers, power-fail output, square-wave and interrupt pins.
 * Assumes asynchronous host strobes and pins (synchronised here), alarm and
 * programming controls from logic on the same clock, and a power-good comparator.
 */
`timescale 1ns/1ns
`default_nettype none

`include "host_bus_cfg.svh"

// How it works
// [RULE_01] low 64 addresses select on-chip registers
// [RULE_02] write on write-strobe rise with chip enable
// [RULE_03] read on-chip location, drive while output enable
// [RULE_04] ram enable follows chip enable when powered
// [RULE_05] ram read enable only off-window, powered, selected
// [RULE_06] host holds chip enable low whole cycle
// [RULE_07] output enable gates own data drivers
// [RULE_08] external read: own drivers off, pass enable
// [RULE_09] square wave 1024Hz, high impedance when off
// [RULE_10] primary interrupt carries chosen alarm, alternate other
// [RULE_11] primary interrupt pulse or level mode
// [RULE_12] power-fail low on protect, high after recovery
// [RULE_13] 17-bit address, 64 on-chip, rest external
// [RULE_14] protection held 150ms after supply returns
// [RULE_15] write spans later fall to earlier rise
// [RULE_16] square wave is crystal divided by 32
// [RULE_17] chip enable ignored internally while power bad
module host_bus_decode_sram_gating #(
	parameter int unsigned REC_CYCLES = `HB_REC_CYCLES,
	parameter int unsigned IRQ_PULSE_CYCLES = `HB_IRQ_PULSE_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [`HB_ADDR_W-1:0] i_addr,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [`HB_DATA_W-1:0] i_dq,
	output logic [`HB_DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic i_power_good,
	input wire logic i_crystal_pins,
	input wire logic i_sqw_enable,
	input wire host_bus_pkg::irq_route_t i_irq_route,
	input wire logic i_irq_pulse_mode,
	input wire logic i_tod_alarm,
	input wire logic i_wdog_alarm,
	output logic o_ram_select_out_n,
	output logic o_ram_read_enable_out_n,
	output logic o_power_fail_out_n,
	output logic o_square_wave_out,
	output logic o_square_wave_oe,
	output logic o_irq_primary_n,
	output logic o_irq_alternate_n
);
	import host_bus_pkg::*;

	localparam int SW = `HB_ADDR_W + 3 + `HB_DATA_W + 2;

	function automatic logic is_onchip(input logic [`HB_ADDR_W-1:0] a);
		return a <= `HB_ONCHIP_LAST;
	endfunction

	// =====================================================================
	// pin synchronisers
	logic [SW-1:0] meta_q;
	logic [SW-1:0] sync_q;
	logic [`HB_ADDR_W-1:0] addr_s;
	logic ce_s, oe_s, we_s, pg_s, xtal_s;
	logic [`HB_DATA_W-1:0] dq_s;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {i_addr, i_ce_n, i_oe_n, i_we_n, i_dq, i_power_good, i_crystal_pins};
			sync_q <= meta_q;
		end
	end

	assign {addr_s, ce_s, oe_s, we_s, dq_s, pg_s, xtal_s} = sync_q;

	// =====================================================================
	// power supervision
	pwr_state_t pwr_q;
	logic [`HB_REC_CNT_W-1:0] rec_cnt_q;
	logic pwr_ok;

	assign pwr_ok = (pwr_q == PWR_GOOD);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_q <= PWR_FAIL;
			rec_cnt_q <= '0;
		end else begin
			case (pwr_q)
				PWR_FAIL: begin
					rec_cnt_q <= '0;
					if (pg_s) begin
						pwr_q <= PWR_RECOVER;
					end
				end
				PWR_RECOVER: begin
					if (!pg_s) begin
						pwr_q <= PWR_FAIL; // RULE_12
					end else if (rec_cnt_q == `HB_REC_CNT_W'(REC_CYCLES - 1)) begin
						pwr_q <= PWR_GOOD; // RULE_14
					end else begin
						rec_cnt_q <= rec_cnt_q + 1'b1;
					end
				end
				PWR_GOOD: begin
					if (!pg_s) begin
						pwr_q <= PWR_FAIL;
					end
				end
				default: pwr_q <= PWR_FAIL;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_power_fail_out_n <= 1'b0;
		end else begin
			o_power_fail_out_n <= pwr_ok && pg_s; // RULE_12
		end
	end

	// =====================================================================
	// address decode and external RAM gating
	logic ce_int, onchip;

	assign ce_int = !ce_s && pwr_ok; // RULE_17
	assign onchip = is_onchip(addr_s); // RULE_01 RULE_13

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ram_select_out_n <= 1'b1;
			o_ram_read_enable_out_n <= 1'b1;
		end else begin
			o_ram_select_out_n <= !ce_int; // RULE_04 RULE_14 RULE_06
			o_ram_read_enable_out_n <= !(ce_int && !onchip && !oe_s); // RULE_05 RULE_08
		end
	end

	// =====================================================================
	// on-chip write: commits when the combined strobe window closes
	logic wr_act_d, wr_act_q, wr_en;
	logic [`HB_ONCHIP_W-1:0] wr_addr_q;
	logic [`HB_DATA_W-1:0] wr_data_q;

	assign wr_act_d = ce_int && !we_s && onchip; // RULE_15
	// a write cut short by power loss is dropped rather than committed
	assign wr_en = wr_act_q && !wr_act_d && pwr_ok; // RULE_02

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_act_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			wr_act_q <= wr_act_d;
			if (wr_act_d) begin
				wr_addr_q <= addr_s[`HB_ONCHIP_W-1:0];
				wr_data_q <= dq_s;
			end
		end
	end

	// =====================================================================
	// on-chip read path
	logic rd_en, rd_oe_q;
	logic [`HB_DATA_W-1:0] rd_data;

	assign rd_en = ce_int && we_s && onchip; // RULE_03

	reg_store #(
		.AW(`HB_ONCHIP_W),
		.DW(`HB_DATA_W)
	) u_store (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_wr_en(wr_en),
		.i_wr_addr(wr_addr_q),
		.i_wr_data(wr_data_q),
		.i_rd_addr(addr_s[`HB_ONCHIP_W-1:0]),
		.o_rd_data(rd_data)
	);

	// enable delayed to line up with the registered memory data
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_oe_q <= 1'b0;
			o_dq_oe <= 1'b0;
			o_dq <= '0;
		end else begin
			rd_oe_q <= rd_en && !oe_s; // RULE_07 RULE_08
			o_dq_oe <= rd_oe_q && rd_en && !oe_s; // RULE_07
			o_dq <= rd_data; // RULE_03
		end
	end

	// =====================================================================
	// square wave from the crystal
	logic xtal_prev_q;
	logic [`HB_SQW_CNT_W-1:0] sqw_cnt_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			xtal_prev_q <= 1'b0;
			sqw_cnt_q <= '0;
			o_square_wave_out <= 1'b0;
			o_square_wave_oe <= 1'b0;
		end else begin
			xtal_prev_q <= xtal_s;
			o_square_wave_oe <= i_sqw_enable; // RULE_09
			if (xtal_s && !xtal_prev_q) begin
				if (sqw_cnt_q == `HB_SQW_HALF_EDGES - 1'b1) begin
					sqw_cnt_q <= '0;
					o_square_wave_out <= !o_square_wave_out; // RULE_16
				end else begin
					sqw_cnt_q <= sqw_cnt_q + 1'b1;
				end
			end
		end
	end

	// =====================================================================
	// interrupt pins
	logic prim_src, alt_src, prim_prev_q;
	logic [`HB_IRQ_CNT_W-1:0] pulse_cnt_q;

	assign prim_src = (i_irq_route == ROUTE_WDOG_PRIMARY) ? i_wdog_alarm : i_tod_alarm; // RULE_10
	assign alt_src = (i_irq_route == ROUTE_WDOG_PRIMARY) ? i_tod_alarm : i_wdog_alarm; // RULE_10

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prim_prev_q <= 1'b0;
			pulse_cnt_q <= '0;
			o_irq_primary_n <= 1'b1;
			o_irq_alternate_n <= 1'b1;
		end else begin
			prim_prev_q <= prim_src;
			o_irq_alternate_n <= !alt_src;
			// counter idles at zero in level mode, so a switch to pulse mode shows no stale pulse
			if (!i_irq_pulse_mode) begin
				pulse_cnt_q <= '0;
			end else if (prim_src && !prim_prev_q) begin
				pulse_cnt_q <= `HB_IRQ_CNT_W'(IRQ_PULSE_CYCLES);
			end else if (pulse_cnt_q != '0) begin
				pulse_cnt_q <= pulse_cnt_q - 1'b1;
			end
			if (i_irq_pulse_mode) begin
				o_irq_primary_n <= !((prim_src && !prim_prev_q) || pulse_cnt_q > 1); // RULE_11
			end else begin
				o_irq_primary_n <= !prim_src; // RULE_11
			end
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	ram_ce_block_a: assert property (!pwr_ok |=> o_ram_select_out_n) // RULE_04
		else $error("ram enable active while power not good");
	ram_ce_pass_a: assert property (pwr_ok && !ce_s |=> !o_ram_select_out_n) // RULE_04
		else $error("ram enable not passed through");
	oer_window_a: assert property (onchip |=> o_ram_read_enable_out_n) // RULE_05
		else $error("ram read enable active for on-chip address");
	oer_pass_a: assert property (ce_int && !onchip && !oe_s |=> !o_ram_read_enable_out_n) // RULE_08
		else $error("ram read enable not passed for external read");
	dq_drive_a: assert property (rd_en && !oe_s ##1 rd_en && !oe_s |=> o_dq_oe) // RULE_07
		else $error("data drivers not enabled for on-chip read");
	dq_quiet_a: assert property (o_dq_oe |-> $past(rd_en) && $past(!oe_s)) // RULE_08
		else $error("data drivers on outside an on-chip read");
	rec_hold_a: assert property ($rose(pwr_ok) |-> $past(rec_cnt_q) == `HB_REC_CNT_W'(REC_CYCLES - 1)) // RULE_14
		else $error("protection released before recovery time");
	pfo_low_a: assert property (!pg_s |=> !o_power_fail_out_n ##1 !pwr_ok) // RULE_12
		else $error("power-fail output not low on supply loss");
	write_gate_a: assert property (wr_en |-> $past(wr_act_q) && pwr_ok) // RULE_17
		else $error("on-chip write without power good");
	sqw_edge_a: assert property ($changed(o_square_wave_out) |-> $past(sqw_cnt_q) == 5'h0f) // RULE_16
		else $error("square wave toggled off divider wrap");
	irq_level_a: assert property (!i_irq_pulse_mode |=> o_irq_primary_n == !$past(prim_src)) // RULE_11
		else $error("primary interrupt level mismatch");

endmodule

`default_nettype wire

// file: dv/ext_sram_model.sv
/*
 * External static RAM on the far side of the host bus block.
 * Assumes active-low enables from the block and a bench that resolves the data bus.
 */
`timescale 1ns/1ns
`default_nettype none

module ext_sram_model (
	input wire logic i_sel_n,
	input wire logic i_rd_n,
	input wire logic [16:0] i_addr,
	output logic [7:0] o_dq,
	output logic o_dq_oe
);
	// =====================================================================
	// read side: a fixed pattern of the address stands in for contents
	assign o_dq_oe = !i_sel_n && !i_rd_n;
	assign o_dq = i_addr[7:0] ^ 8'ha5;
endmodule

`default_nettype wire

// file: dv/host_bus_decode_sram_gating_tb_top.sv
/*
 * Self-checking bench for the host bus decode and RAM gating block.
 * Assumes the block's package and config header are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

`include "host_bus_cfg.svh"

module host_bus_decode_sram_gating_tb_top;
	import host_bus_pkg::*;
	localparam int REC = 20;
	localparam int PULSE = 16;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce_n = 1'b1;
	logic oe_n = 1'b1;
	logic we_n = 1'b1;
	logic pg = 1'b1;
	logic xtal = 1'b0;
	logic sqw_en = 1'b0;
	logic pulse_md = 1'b0;
	logic tod = 1'b0;
	logic wdog = 1'b0;
	irq_route_t route = ROUTE_TOD_PRIMARY;
	logic [16:0] addr = 17'h00000;
	logic [7:0] host_dq = 8'h00;
	logic [7:0] dq, bus, ram_dq;
	logic dq_oe, sel_n, rd_n, pf_n, sq, sq_oe, ia_n, ib_n, ram_oe;
	int error_cnt = 0;
	int total_checks = 0;

	always #50 clk = ~clk;
	// nobody driving: a pattern that flips every half cycle, never a held value
	assign bus = dq_oe ? dq : ram_oe ? ram_dq : !we_n ? host_dq : {4{clk, ~clk}};

	host_bus_decode_sram_gating #(.REC_CYCLES(REC), .IRQ_PULSE_CYCLES(PULSE)) dut_u (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_dq(bus), .o_dq(dq), .o_dq_oe(dq_oe), .i_power_good(pg),
		.i_crystal_pins(xtal), .i_sqw_enable(sqw_en), .i_irq_route(route),
		.i_irq_pulse_mode(pulse_md), .i_tod_alarm(tod), .i_wdog_alarm(wdog),
		.o_ram_select_out_n(sel_n), .o_ram_read_enable_out_n(rd_n),
		.o_power_fail_out_n(pf_n), .o_square_wave_out(sq), .o_square_wave_oe(sq_oe),
		.o_irq_primary_n(ia_n), .o_irq_alternate_n(ib_n));

	ext_sram_model ram_u (.i_sel_n(sel_n), .i_rd_n(rd_n), .i_addr(addr), .o_dq(ram_dq),
		.o_dq_oe(ram_oe));

	// =====================================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wait_pf(output int n);
		n = 0;
		while (pf_n !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		if (n >= 200) begin
			error_cnt++;
			$display("[ERR] power_fail_high expected 1 seen %b", pf_n);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		addr = a;
		host_dq = d;
		ce_n = 1'b0;
		we_n = 1'b0;
		step(6);
		we_n = 1'b1;
		step(4);
		ce_n = 1'b1;
		step(4);
	endtask
	task automatic rel;
		ce_n = 1'b1;
		oe_n = 1'b1;
		step(5);
		chk1("dq_oe_off", 1'b0, dq_oe);
	endtask
	task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
		addr = a;
		ce_n = 1'b0;
		step(6);
		chk1("dq_oe_no_oe", 1'b0, dq_oe);
		oe_n = 1'b0;
		step(6);
		chk1("dq_oe", 1'b1, dq_oe);
		chk8("rd_data", e, bus);
		chk1("ram_rd_n", 1'b1, rd_n);
		chk1("ram_sel_n", 1'b0, sel_n);
		rel();
	endtask

	// =====================================================================
	// scenarios
	task automatic t_power_up;
		int n;
		chk1("pf_rst", 1'b0, pf_n);
		chk1("sel_rst", 1'b1, sel_n);
		chk1("sq_oe_rst", 1'b0, sq_oe);
		rst_b = 1'b1;
		addr = 17'h00040;
		ce_n = 1'b0;
		oe_n = 1'b0;
		step(4);
		chk1("sel_recover", 1'b1, sel_n);
		chk1("rd_recover", 1'b1, rd_n);
		wait_pf(n);
		chk1("rec_len", 1'b1, n + 4 >= REC);
		rel();
		$display("test power_up done");
	endtask
	task automatic t_onchip;
		wr(17'h0003f, 8'h3c);
		wr(17'h00000, 8'hc5);
		// chip enable rises first here, so that edge closes the write window
		addr = 17'h00001;
		host_dq = 8'h5a;
		ce_n = 1'b0;
		we_n = 1'b0;
		step(6);
		ce_n = 1'b1;
		step(4);
		we_n = 1'b1;
		step(4);
		rd_chk(17'h0003f, 8'h3c);
		rd_chk(17'h00000, 8'hc5);
		rd_chk(17'h00001, 8'h5a);
		$display("test onchip done");
	endtask
	task automatic t_ext;
		logic [16:0] a [2] = '{17'h00040, 17'h1ffff};
		foreach (a[i]) begin
			addr = a[i];
			ce_n = 1'b0;
			oe_n = 1'b0;
			step(6);
			chk1("ram_rd_n_ext", 1'b0, rd_n);
			chk1("dq_oe_ext", 1'b0, dq_oe);
			chk8("ram_data", a[i][7:0] ^ 8'ha5, bus);
			rel();
		end
		$display("test ext done");
	endtask
	task automatic t_pfail;
		int n;
		pg = 1'b0;
		step(4);
		chk1("pf_low", 1'b0, pf_n);
		addr = 17'h00040;
		ce_n = 1'b0;
		oe_n = 1'b0;
		step(6);
		chk1("sel_pfail", 1'b1, sel_n);
		chk1("rd_pfail", 1'b1, rd_n);
		rel();
		wr(17'h0003f, 8'h99);
		pg = 1'b1;
		wait_pf(n);
		chk1("rec_len2", 1'b1, n + 4 >= REC);
		rd_chk(17'h0003f, 8'h3c);
		$display("test pfail done");
	endtask
	task automatic t_irq;
		tod = 1'b1;
		step(3);
		chk1("ia_tod", 1'b0, ia_n);
		chk1("ib_idle", 1'b1, ib_n);
		wdog = 1'b1;
		step(3);
		chk1("ib_wdog", 1'b0, ib_n);
		tod = 1'b0;
		wdog = 1'b0;
		route = ROUTE_WDOG_PRIMARY;
		pulse_md = 1'b1;
		step(3);
		chk1("ia_clear", 1'b1, ia_n);
		wdog = 1'b1;
		tod = 1'b1;
		step(3);
		chk1("ia_pulse", 1'b0, ia_n);
		chk1("ib_tod", 1'b0, ib_n);
		step(PULSE - 4);
		chk1("ia_pulse_hold", 1'b0, ia_n);
		step(4);
		chk1("ia_pulse_end", 1'b1, ia_n);
		wdog = 1'b0;
		tod = 1'b0;
		$display("test irq done");
	endtask
	task automatic t_sqw;
		logic [7:0] tog;
		logic prev;
		tog = 8'h00;
		sqw_en = 1'b1;
		step(2);
		prev = sq;
		// 64 crystal rising edges, 4 bench cycles each, should give 4 toggles
		for (int i = 0; i < 264; i++) begin
			xtal = (i < 256) && ((i / 2) % 2 == 1);
			step(1);
			if (sq !== prev) begin
				tog++;
			end
			prev = sq;
		end
		chk8("sqw_toggles", 8'h04, tog);
		chk1("sq_oe_on", 1'b1, sq_oe);
		sqw_en = 1'b0;
		step(2);
		chk1("sq_oe_off", 1'b0, sq_oe);
		$display("test sqw done");
	endtask

	initial begin
		step(2);
		t_power_up();
		t_onchip();
		t_ext();
		t_pfail();
		t_irq();
		t_sqw();
		tally_and_finish();
	end
endmodule

`default_nettype wire
